// File: core/mcc_top.v
// Mouse and calendar controller with AHB-Lite host port.
// Assumes synchronous mouse and calendar pins on mclk.
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`default_nettype none
`include "mcc_defines.vh"
module mcc_top (
   input wire mclk,
   input wire sys_rst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire [5:0] mouse_input_port,
   input wire [2:0] button_n,
   input wire cal_power_fail,
   input wire cal_data_in,
   output reg cal_clk,
   output reg cal_data_out,
   output reg cal_data_oe,
   output reg cal_sel,
   output reg host_irq_pulse,
   output reg irq
);
   localparam S_RUN = 3'd0;
   localparam S_DISP = 3'd1;
   localparam S_SER = 3'd2;
   localparam S_DONE = 3'd3;
   // Working state
   reg [2:0] state_reg;
   reg [7:0] in_buf [0:4];
   reg [3:0] in_cnt_reg;
   reg cmd_flag_reg;
   reg in_full_reg;
   reg out_full_reg;
   reg [7:0] out_data_reg;
   reg [7:0] out_buf [0:4];
   reg [2:0] out_len_reg;
   reg [2:0] out_ptr_reg;
   reg [2:0] btn_reg;
   reg pfail_reg;
   reg [7:0] motion_thr_reg;
   reg [7:0] button_en_reg;
   reg [7:0] timer_en_reg;
   reg [31:0] timer_reg;
   reg [2:0] irq_st_reg;
   reg [2:0] irq_msk_reg;
   reg clr_acc_reg;
   reg ser_read_reg;
   reg [5:0] ser_bit_reg;
   reg [7:0] ser_div_reg;
   reg [31:0] ser_sh_reg;
   // AHB address phase capture
   reg wr_ph_reg;
   reg rd_ph_reg;
   reg [7:0] ad_reg;
   wire [15:0] acc_x;
   wire [15:0] acc_y;
   integer i;
   // Per-axis decoders from one generate loop
   wire [15:0] acc_w [0:1];
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : axis
         mcc_quad_axis u_axis (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .phase_a(mouse_input_port[2*g]),
            .phase_b(mouse_input_port[2*g+1]),
            .clear(clr_acc_reg),
            .acc(acc_w[g])
         );
      end
   endgenerate
   assign acc_x = acc_w[0];
   assign acc_y = acc_w[1];
   wire busy = (state_reg != S_RUN);
   wire tick = (timer_reg == 32'd0);
   wire out_idle = (out_ptr_reg == out_len_reg) && !out_full_reg;
   wire [15:0] mag_x = acc_x[15] ? (16'h0000 - acc_x) : acc_x;
   wire [15:0] mag_y = acc_y[15] ? (16'h0000 - acc_y) : acc_y;
   wire motion_ev = (motion_thr_reg != 8'h00) && out_idle &&
      ((mag_x >= {8'h00, motion_thr_reg}) || (mag_y >= {8'h00, motion_thr_reg}));
   wire btn_chg = (button_n != btn_reg);
   wire button_ev = (button_en_reg != 8'h00) && btn_chg && out_idle;
   wire timed_ev = (timer_en_reg != 8'h00) && tick && out_idle &&
      ((acc_x != 16'h0000) || (acc_y != 16'h0000));
   wire ahb_go = hsel && hready && htrans[1];
   wire [7:0] st_byte = {pfail_reg, btn_reg, cmd_flag_reg, 1'b0, in_full_reg,
      out_full_reg};
   wire wr_data = wr_ph_reg && (ad_reg == `MCC_A_DATA);
   wire wr_cmd = wr_ph_reg && (ad_reg == `MCC_A_CMD);
   wire rd_data = rd_ph_reg && (ad_reg == `MCC_A_DATA);
   // Command length check for the buffered header
   reg [3:0] need_len;
   always @* begin
      case (in_buf[0])
         `MCC_H_SET: need_len = `MCC_LEN_SET;
         `MCC_H_READ: need_len = `MCC_LEN_READ;
         `MCC_H_MOTION: need_len = `MCC_LEN_ONE;
         `MCC_H_TIMER: need_len = `MCC_LEN_ONE;
         default: need_len = 4'd0;
      endcase
   end
   // Read data mux, decoded from the address phase
   reg [31:0] rd_mux;
   always @* begin
      case (haddr[7:0])
         `MCC_A_STATUS: rd_mux = {24'h000000, st_byte};
         `MCC_A_DATA: rd_mux = {24'h000000, out_data_reg};
         `MCC_A_IRQST: rd_mux = {29'h00000000, irq_st_reg};
         `MCC_A_IRQMSK: rd_mux = {29'h00000000, irq_msk_reg};
         `MCC_A_CFG: rd_mux = {8'h00, timer_en_reg, button_en_reg, motion_thr_reg};
         `MCC_A_ACCX: rd_mux = {16'h0000, acc_x};
         `MCC_A_ACCY: rd_mux = {16'h0000, acc_y};
         default: rd_mux = 32'h00000000;
      endcase
   end
   // AHB slave: zero wait, always OKAY
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ph_reg <= 1'b0;
         rd_ph_reg <= 1'b0;
         ad_reg <= 8'h00;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_ph_reg <= ahb_go && hwrite;
         rd_ph_reg <= ahb_go && !hwrite;
         if (ahb_go)
            ad_reg <= haddr[7:0];
         if (ahb_go && !hwrite)
            hrdata <= rd_mux; // Stands through the zero-wait data phase
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
   // Controller cycle, input buffer, output packet and calendar link
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= S_RUN;
         for (i = 0; i < 5; i = i + 1) begin
            in_buf[i] <= 8'h00;
            out_buf[i] <= 8'h00;
         end
         in_cnt_reg <= 4'd0;
         cmd_flag_reg <= 1'b0;
         in_full_reg <= 1'b0;
         out_full_reg <= 1'b0;
         out_data_reg <= 8'h00;
         out_len_reg <= 3'd0;
         out_ptr_reg <= 3'd0;
         btn_reg <= 3'b111;
         pfail_reg <= 1'b0;
         motion_thr_reg <= 8'h00;
         button_en_reg <= 8'h00;
         timer_en_reg <= 8'h00;
         timer_reg <= `MCC_TICK_CYC - 1;
         irq_st_reg <= 3'b000;
         irq_msk_reg <= 3'b000;
         clr_acc_reg <= 1'b0;
         ser_read_reg <= 1'b0;
         ser_bit_reg <= 6'd0;
         ser_div_reg <= 8'h00;
         ser_sh_reg <= 32'h00000000;
         cal_clk <= 1'b0;
         cal_data_out <= 1'b0;
         cal_data_oe <= 1'b0;
         cal_sel <= 1'b0;
         host_irq_pulse <= 1'b0;
         irq <= 1'b0;
      end else begin
         clr_acc_reg <= 1'b0;
         host_irq_pulse <= 1'b0;
         irq <= |(irq_st_reg & irq_msk_reg);
         timer_reg <= tick ? (`MCC_TICK_CYC - 1) : (timer_reg - 32'd1);
         // Host writes fill the input buffer; command port sets the flag
         if ((wr_data || wr_cmd) && in_cnt_reg < 4'd5 && !cmd_flag_reg) begin
            in_buf[in_cnt_reg[2:0]] <= hwdata[7:0];
            in_cnt_reg <= in_cnt_reg + 4'd1;
            if (wr_cmd)
               cmd_flag_reg <= 1'b1;
         end
         in_full_reg <= 1'b0;
         if (rd_data)
            out_full_reg <= 1'b0;
         if (wr_ph_reg && ad_reg == `MCC_A_IRQMSK)
            irq_msk_reg <= hwdata[2:0];
         // Write one to clear first, so a same-cycle set below wins
         if (wr_ph_reg && ad_reg == `MCC_A_IRQST)
            irq_st_reg <= irq_st_reg & ~hwdata[2:0];
         // Power-fail flag set wins over clearing
         if (cal_power_fail) begin
            pfail_reg <= 1'b1;
         end
         case (state_reg)
            S_RUN: begin
               if (btn_chg)
                  btn_reg <= button_n;
               if (motion_ev || button_ev || timed_ev) begin
                  out_buf[0] <= timed_ev ? `MCC_P_A : (motion_ev ? `MCC_P_M : `MCC_P_B);
                  out_buf[1] <= acc_x[15:8];
                  out_buf[2] <= acc_x[7:0];
                  out_buf[3] <= acc_y[15:8];
                  out_buf[4] <= acc_y[7:0];
                  out_len_reg <= 3'd5;
                  out_ptr_reg <= 3'd0;
                  clr_acc_reg <= 1'b1;
               end else if (cmd_flag_reg) begin
                  state_reg <= S_DISP;
               end else if (!out_full_reg && out_ptr_reg != out_len_reg && !rd_data) begin
                  out_data_reg <= out_buf[out_ptr_reg];
                  out_ptr_reg <= out_ptr_reg + 3'd1;
                  out_full_reg <= 1'b1;
                  host_irq_pulse <= 1'b1;
                  irq_st_reg[`MCC_IRQ_BYTE] <= 1'b1;
               end else if (tick && out_full_reg) begin
                  host_irq_pulse <= 1'b1;
               end
            end
            S_DISP: begin
               state_reg <= S_RUN;
               in_cnt_reg <= 4'd0;
               cmd_flag_reg <= 1'b0;
               if (need_len == 4'd0 || in_cnt_reg != need_len) begin
                  irq_st_reg[`MCC_IRQ_BAD] <= 1'b1;
               end else if (in_buf[0] == `MCC_H_SET) begin
                  // Order minutes, hours, day, month
                  ser_sh_reg <= {in_buf[1], in_buf[2], in_buf[3], in_buf[4]};
                  ser_read_reg <= 1'b0;
                  ser_bit_reg <= 6'd32;
                  ser_div_reg <= `MCC_SER_HALF;
                  cal_sel <= 1'b1;
                  cal_data_oe <= 1'b1;
                  state_reg <= S_SER;
               end else if (in_buf[0] == `MCC_H_READ) begin
                  ser_read_reg <= 1'b1;
                  ser_bit_reg <= 6'd32;
                  ser_div_reg <= `MCC_SER_HALF;
                  cal_sel <= 1'b1;
                  state_reg <= S_SER;
               end else if (in_buf[0] == `MCC_H_MOTION) begin
                  motion_thr_reg <= in_buf[1];
               end else begin
                  timer_en_reg <= in_buf[1];
               end
            end
            S_SER: begin
               // MSB-first bit shift, one bit per clock pair
               if (ser_div_reg != 8'h00) begin
                  ser_div_reg <= ser_div_reg - 8'h01;
               end else if (!cal_clk) begin
                  cal_clk <= 1'b1;
                  cal_data_out <= ser_sh_reg[31];
                  ser_div_reg <= `MCC_SER_HALF;
               end else begin
                  cal_clk <= 1'b0;
                  ser_sh_reg <= {ser_sh_reg[30:0], cal_data_in};
                  ser_bit_reg <= ser_bit_reg - 6'd1;
                  ser_div_reg <= `MCC_SER_HALF;
                  if (ser_bit_reg == 6'd1)
                     state_reg <= S_DONE;
               end
            end
            S_DONE: begin
               cal_sel <= 1'b0;
               cal_data_oe <= 1'b0;
               state_reg <= S_RUN;
               if (ser_read_reg) begin
                  out_buf[0] <= `MCC_P_R;
                  out_buf[1] <= ser_sh_reg[31:24];
                  out_buf[2] <= ser_sh_reg[23:16];
                  out_buf[3] <= ser_sh_reg[15:8];
                  out_buf[4] <= ser_sh_reg[7:0];
                  out_len_reg <= 3'd5;
                  out_ptr_reg <= 3'd0;
               end else if (!cal_power_fail) begin
                  pfail_reg <= 1'b0;
               end
            end
            default: state_reg <= S_RUN;
         endcase
         if (cal_power_fail && !pfail_reg)
            irq_st_reg[`MCC_IRQ_PFAIL] <= 1'b1;
         if (wr_ph_reg && ad_reg == `MCC_A_CFG)
            button_en_reg <= hwdata[15:8];
      end
   end
endmodule
`default_nettype wire

// File: pkg/mcc_defines.vh
// Constants for the mouse and calendar controller.
// Assumes inclusion by bare name from the core design files.
`ifndef MCC_DEFINES_VH
`define MCC_DEFINES_VH
// AHB register byte addresses
`define MCC_A_STATUS 8'h00
`define MCC_A_DATA 8'h04
`define MCC_A_CMD 8'h08
`define MCC_A_IRQST 8'h0c
`define MCC_A_IRQMSK 8'h10
`define MCC_A_CFG 8'h14
`define MCC_A_ACCX 8'h18
`define MCC_A_ACCY 8'h1c
// Host status bit positions
`define MCC_ST_OUTF 0
`define MCC_ST_INF 1
`define MCC_ST_CMDF 3
`define MCC_ST_BTN0 4
`define MCC_ST_PFAIL 7
// Command headers and lengths
`define MCC_H_SET 8'h01
`define MCC_H_READ 8'h02
`define MCC_H_MOTION 8'h08
`define MCC_H_TIMER 8'h20
`define MCC_LEN_SET 4'd5
`define MCC_LEN_READ 4'd1
`define MCC_LEN_ONE 4'd2
// Packet headers
`define MCC_P_A 8'h41
`define MCC_P_M 8'h4d
`define MCC_P_B 8'h42
`define MCC_P_R 8'h52
// Timer: 25 ms tick (about 40 per second) at 40 MHz
`define MCC_TICK_NS 25000000
`define MCC_CLK_NS 25
`define MCC_TICK_CYC (`MCC_TICK_NS / `MCC_CLK_NS)
// Calendar serial bit half period, less one, in cycles
`define MCC_SER_HALF 8'd20
// Interrupt status bits
`define MCC_IRQ_BYTE 0
`define MCC_IRQ_PFAIL 1
`define MCC_IRQ_BAD 2
`endif

// File: core/mcc_quad_axis.v
// One quadrature axis decoder with signed accumulator.
// Assumes phase inputs already synchronous to mclk.
`default_nettype none
`include "mcc_defines.vh"
module mcc_quad_axis (
   input wire mclk,
   input wire sys_rst,
   input wire phase_a,
   input wire phase_b,
   input wire clear,
   output wire [15:0] acc
);
   reg [1:0] prev_reg;
   reg [15:0] acc_reg;
   wire [1:0] cur = {phase_a, phase_b};
   reg [1:0] step;
   // Gray step decode: 01 up, 11 down, 00 none or null
   always @* begin
      step = 2'b00;
      case ({prev_reg, cur})
         4'b0001, 4'b0111, 4'b1110, 4'b1000: step = 2'b01;
         4'b0010, 4'b1011, 4'b1101, 4'b0100: step = 2'b11;
         default: step = 2'b00; // Double change is null
      endcase
   end
   // Saturating accumulator, cleared on motion, button or timed packet build
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         prev_reg <= 2'b00;
         acc_reg <= 16'h0000;
      end else begin
         prev_reg <= cur;
         if (clear)
            acc_reg <= 16'h0000;
         else if (step == 2'b01 && acc_reg != 16'h7fdf)
            acc_reg <= acc_reg + 16'h0001;
         else if (step == 2'b11 && acc_reg != 16'h8021)
            acc_reg <= acc_reg - 16'h0001;
      end
   end
   assign acc = acc_reg;
endmodule
`default_nettype wire

// File: tb/mcc_top_checker.sv
// Assertion checker for the mouse and calendar controller top.
// Assumes binding to mcc_top and sight of its ports only.
`default_nettype none
module mcc_top_checker (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic cal_clk,
   input wire logic cal_data_oe,
   input wire logic cal_sel,
   input wire logic host_irq_pulse,
   input wire logic irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // Host reads of status and of an unmapped word
   sequence s_rd_st;
      hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h00;
   endsequence
   sequence s_rd_gap;
      hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h20;
   endsequence
   AST_BUS_OK: assert property (hreadyout && !hresp)
      else $error("bus wait or error response seen");
   AST_RST_OUT: assert property ($fell(sys_rst) |-> !irq && !cal_sel && !host_irq_pulse)
      else $error("output active right after reset");
   AST_PULSE: assert property (host_irq_pulse |=> !host_irq_pulse)
      else $error("interrupt pulse longer than one cycle");
   AST_HALT: assert property (cal_sel |-> !host_irq_pulse)
      else $error("host signalled during calendar transfer");
   AST_OE: assert property (cal_data_oe |-> cal_sel)
      else $error("calendar data driven while deselected");
   AST_CLK_IDLE: assert property (!cal_sel && !$past(cal_sel) |-> !cal_clk)
      else $error("link clock runs outside a frame");
   AST_CLK_HALF: assert property ($rose(cal_clk) |=> $stable(cal_clk) [*8])
      else $error("link clock high phase too short");
   AST_STATUS: assert property (s_rd_st |-> ##1 (hrdata[31:8] == 24'h0 && hrdata[2:1] == 2'b00))
      else $error("status reserved bits not zero");
   AST_GAP: assert property (s_rd_gap |-> ##1 hrdata == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind mcc_top mcc_top_checker i_chk (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .cal_clk(cal_clk), .cal_data_oe(cal_data_oe),
   .cal_sel(cal_sel), .host_irq_pulse(host_irq_pulse), .irq(irq));
`default_nettype wire

// File: tb/mcc_cal_model.sv
// Behavioural calendar chip on the serial link.
// Assumes 32-bit frames, most significant bit first.
`default_nettype none
module mcc_cal_model (
   input wire logic cal_clk,
   input wire logic cal_sel,
   input wire logic cal_data_out,
   input wire logic cal_data_oe,
   output var logic cal_data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] time_reg = 32'h0;
   logic [31:0] rd_reg = 32'h0;
   logic [31:0] wr_reg = 32'h0;
   int bits_in = 0;
   // Idle line level at power-up
   initial cal_data_in = 1'b0;
   // Start of frame
   always @(posedge cal_sel) begin
      rd_reg = time_reg;
      bits_in = 0;
   end
   // Read bits leave on the rising clock; written bits taken mid-phase
   always @(posedge cal_clk) begin
      if (cal_sel && !cal_data_oe) begin
         cal_data_in = rd_reg[31];
         rd_reg = {rd_reg[30:0], 1'b0};
      end else if (cal_sel) begin
         #250;
         wr_reg = {wr_reg[30:0], cal_data_out};
         bits_in++;
      end
   end
   // End of frame: keep a whole write, flip the released line
   always @(negedge cal_sel) begin
      if (bits_in == 32) time_reg = wr_reg;
      cal_data_in = ~cal_data_in;
   end
endmodule
`default_nettype wire

// File: tb/mcc_top_tb.sv
// Bench for the mouse and calendar controller over AHB-Lite.
// Assumes the calendar model on the serial link.
`default_nettype none
module mcc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, sys_rst, hwrite, cal_power_fail, cal_data_in, hreadyout, hresp;
   logic cal_clk, cal_data_out, cal_data_oe, cal_sel, host_irq_pulse, irq;
   logic [1:0] htrans;
   logic [2:0] button_n;
   logic [5:0] mouse_input_port;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [3:0] mv [6] = '{4'h9, 4'hf, 4'he, 4'hf, 4'hc, 4'hd};
   int err_count = 0;
   int tests_run = 0;
   int pulses = 0;
   int p0;
   mcc_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .mouse_input_port(mouse_input_port), .button_n(button_n),
      .cal_power_fail(cal_power_fail), .cal_data_in(cal_data_in), .cal_clk(cal_clk),
      .cal_data_out(cal_data_out), .cal_data_oe(cal_data_oe), .cal_sel(cal_sel),
      .host_irq_pulse(host_irq_pulse), .irq(irq));
   mcc_cal_model i_cal (.cal_clk(cal_clk), .cal_sel(cal_sel), .cal_data_out(cal_data_out),
      .cal_data_oe(cal_data_oe), .cal_data_in(cal_data_in));
   // Clock and pulse count
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(negedge mclk) if (host_irq_pulse === 1'b1) pulses++;
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Bounded wait for ready
   task automatic wt();
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk("hready", 32'h1, {31'h0, hreadyout});
         wrap_up();
      end
   endtask
   // One single-word transfer
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge mclk);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      wt();
      htrans <= 2'b00;
      hwdata <= w ? d : 32'h0;
      wt();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task automatic rc(input string name, input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] m = 32'hffffffff);
      xfer(a, 1'b0, 32'h0);
      chk(name, exp, rd & m);
   endtask
   // Data bytes to DATA, last one to CMD
   task automatic send(input logic [7:0] q[$]);
      foreach (q[i]) wr(i == q.size() - 1 ? 8'h08 : 8'h04, {24'h0, q[i]});
   endtask
   task automatic poll(input int b, input logic v);
      int n;
      n = 0;
      do begin
         xfer(8'h00, 1'b0, 32'h0);
         n++;
      end while (rd[b] !== v && n < 3000);
      if (n >= 3000) begin
         chk("status poll", {31'h0, v}, {31'h0, rd[b]});
         wrap_up();
      end
   endtask
   task automatic pkt(input logic [7:0] q[$]);
      foreach (q[i]) begin
         poll(0, 1'b1);
         rc("packet byte", 8'h04, {24'h0, q[i]}, 32'hff);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      sys_rst = 1'b1;
      htrans = 2'b00;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      mouse_input_port = 6'h00;
      button_n = 3'b111;
      cal_power_fail = 1'b0;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      rc("status", 8'h00, 32'h70);
      rc("acc x", 8'h18, 32'h0, 32'hffff);
      rc("cfg", 8'h14, 32'h0);
      rc("unmapped", 8'h20, 32'h0);
      $display("test reset done");
      // Gray steps with a reversal and a double jump
      foreach (mv[i]) begin
         @(posedge mclk);
         mouse_input_port <= {2'b00, mv[i]};
         repeat (8) @(posedge mclk);
      end
      // Phase a leading b counts down: x nets -3, y nets +2
      rc("acc x", 8'h18, 32'hfffd, 32'hffff);
      rc("acc y", 8'h1c, 32'h2, 32'hffff);
      $display("test motion done");
      wr(8'h10, 32'h0);
      wr(8'h14, 32'h100);
      rc("cfg", 8'h14, 32'h100, 32'hff00);
      p0 = pulses;
      button_n <= 3'b110;
      poll(0, 1'b1);
      rc("status button", 8'h00, 32'h61);
      rc("irq status", 8'h0c, 32'h1, 32'h1);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(8'h10, 32'h1);
      rc("irq status", 8'h0c, 32'h1, 32'h1);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(8'h0c, 32'h1);
      rc("irq cleared", 8'h0c, 32'h0, 32'h1);
      chk("irq after clear", 32'h0, {31'h0, irq});
      pkt('{8'h42, 8'hff, 8'hfd, 8'h00, 8'h02});
      chk("pulses", 32'd5, pulses - p0);
      rc("status empty", 8'h00, 32'h60);
      rc("acc x", 8'h18, 32'h0, 32'hffff);
      rc("acc y", 8'h1c, 32'h0, 32'hffff);
      wr(8'h14, 32'h0);
      button_n <= 3'b111;
      $display("test button done");
      cal_power_fail <= 1'b1;
      poll(7, 1'b1);
      rc("irq pfail", 8'h0c, 32'h2, 32'h2);
      cal_power_fail <= 1'b0;
      rc("pfail held", 8'h00, 32'hf0);
      send('{8'h01, 8'h59, 8'h23, 8'h31, 8'h12});
      poll(3, 1'b0);
      poll(7, 1'b0);
      chk("cal time", 32'h59233112, i_cal.time_reg);
      send('{8'h02});
      pkt('{8'h52, 8'h59, 8'h23, 8'h31, 8'h12});
      $display("test calendar done");
      send('{8'h01, 8'h05});
      poll(3, 1'b0);
      rc("bad count", 8'h0c, 32'h4, 32'h4);
      wr(8'h0c, 32'h4);
      send('{8'h77});
      poll(3, 1'b0);
      rc("bad header", 8'h0c, 32'h4, 32'h4);
      chk("cal kept", 32'h59233112, i_cal.time_reg);
      $display("test bad command done");
      wrap_up();
   end
endmodule
`default_nettype wire
